// >>> hdl/gpcr_pkg.sv
// package: register map, field positions and carrier types of the pin control block
package gpcr_pkg;

  // ---------------------------------------------------------------
  // register offsets (printed offsets are not all multiples of four,
  // so each is an index and the byte address is four times it)
  // ---------------------------------------------------------------
  localparam logic [15:0] GPCR_IDX_FUNC_CTRL = 16'hc006;
  localparam logic [15:0] GPCR_IDX_OUT_LO    = 16'hc01e;
  localparam logic [15:0] GPCR_IDX_IN_LO     = 16'hc020;
  localparam logic [15:0] GPCR_IDX_DIR_LO    = 16'hc022;
  localparam logic [15:0] GPCR_IDX_OUT_HI    = 16'hc024;
  localparam logic [15:0] GPCR_IDX_IN_HI     = 16'hc026;
  localparam logic [15:0] GPCR_IDX_DIR_HI    = 16'hc028;
  localparam logic [15:0] GPCR_IDX_IRQ_STAT  = 16'hc02a;
  localparam logic [15:0] GPCR_IDX_IRQ_MASK  = 16'hc02c;
  localparam logic [15:0] GPCR_IDX_CHIP_IEN  = 16'hc02e;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int GPCR_BIT_WPROT    = 15;
  localparam int GPCR_BIT_TXEN_RT  = 14;
  localparam int GPCR_BIT_ALT_SS   = 11;
  localparam int GPCR_MODE_HI      = 10;
  localparam int GPCR_MODE_LO      = 8;
  localparam int GPCR_BIT_HSS_EN   = 7;
  localparam int GPCR_BIT_SPI_EN   = 5;
  localparam int GPCR_BIT_IRQ_POL  = 1;
  localparam int GPCR_BIT_IRQ_EN   = 0;
  localparam logic [15:0] GPCR_CTRL_WMASK = 16'hcfa3;

  // writable bits of the high-word data and direction registers
  localparam logic [15:0] GPCR_HI_MASK    = 16'he1f8;

  // pin positions
  localparam int GPCR_PIN_EXTERNAL_INTERRUPT_ZERO    = 24;
  localparam int GPCR_PIN_TXEN    = 30;
  localparam int GPCR_PIN_SS_NORM = 9;
  localparam int GPCR_PIN_SS_ALT  = 15;

  // reset values
  localparam logic [15:0] GPCR_RST_WORD = 16'h0000;

  // status / mask / chip enable layout
  localparam int GPCR_ST_EXTERNAL_INTERRUPT_ZERO = 0;
  localparam int GPCR_ST_WPV  = 1;
  localparam int GPCR_ST_W    = 2;
  localparam int GPCR_CHIP_IEN_GPIO = 0;

  typedef enum logic [2:0] {
    GPCR_MODE_GPIO = 3'b000,
    GPCR_MODE_RSV1 = 3'b001,
    GPCR_MODE_RSV2 = 3'b010,
    GPCR_MODE_RSV3 = 3'b011,
    GPCR_MODE_RSV4 = 3'b100,
    GPCR_MODE_HOST = 3'b101,
    GPCR_MODE_SCAN = 3'b110,
    GPCR_MODE_RSV7 = 3'b111
  } gpcr_mode_e;

  // peripheral side of the pin mux
  typedef struct packed {
    logic       hss_oe;
    logic [3:0] hss_do;
    logic       spi_oe;
    logic [3:0] spi_do;
    logic       txen;
    logic [31:0] host_oe;
    logic [31:0] host_do;
  } gpcr_periph_s;

  // whole state of the block
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] out_lo;
    logic [15:0] out_hi;
    logic [15:0] dir_lo;
    logic [15:0] dir_hi;
    logic [31:0] pin_smp;
    logic [GPCR_ST_W-1:0] stat;
    logic [GPCR_ST_W-1:0] mask;
    logic        chip_ien;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [31:0] pin_o;
    logic [31:0] pin_oe_n;
    logic        irq;
  } gpcr_state_s;

endpackage

// >>> hdl/gpcr_top.sv
// module: pin function control, pin data registers and external interrupt zero
// What this block does
// - write protect bit 15 locks mode-select field until chip reset.
// - bit 14 set routes transmitter enable status onto pin 30.
// - serial peripheral active and bit 11 set moves slave select to pin 15.
// - mode field picks pin use; 000 plain pins, 101 parallel host port.
// - bit 7 routes high speed serial link to pins 15..12.
// - bit 5 routes serial peripheral link to pins 11..8.
// - external interrupt zero comes from pin 24, polarity set by control.
// - bit 1 one picks rising edge, zero picks falling edge.
// - interrupt signalled only with bit 0 and chip enable bit set.
// - low output word drives pins 15..0, high word pins 31..29 and 24..19.
// - output data read returns last written value, not pin levels.
// - output bit one drives pin high, zero drives it low.
// - direction bit one makes pin output, zero makes it input.
// - input data bits reflect sampled pin levels.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module gpcr_top
  import gpcr_pkg::*;
(
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         psel_in,
  input  wire logic         penable_in,
  input  wire logic         pwrite_in,
  input  wire logic [31:0]  paddr_in,
  input  wire logic [31:0]  pwdata_in,
  input  wire logic [3:0]   pstrb_in,
  input  wire logic [31:0]  pin_in,
  input  wire gpcr_periph_s periph_in,
  output logic              pready_out,
  output logic [31:0]       prdata_out,
  output logic              pslverr_out,
  output logic [31:0]       pin_out,
  output logic [31:0]       pin_oe_n_out,
  output logic              irq_out
);

  gpcr_state_s st_r;
  gpcr_state_s st_nxt;

  // ---------------------------------------------------------------
  // register access and pin mux
  // ---------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic [15:0] idx;
  logic [15:0] wd;
  logic        hit;
  logic [15:0] rd;
  logic [2:0]  mode;
  logic        edge_seen;
  logic        external_interrupt_zero_now;
  logic        external_interrupt_zero_prev;
  logic [31:0] po;
  logic [31:0] oe;

  always_comb begin
    st_nxt    = st_r;
    acc       = psel_in && penable_in && !st_r.pready;
    wr        = acc && pwrite_in && (pstrb_in[1:0] == 2'b11);
    idx       = paddr_in[17:2];
    wd        = pwdata_in[15:0];
    hit       = 1'b1;
    rd        = 16'h0000;
    mode      = st_r.ctrl[GPCR_MODE_HI:GPCR_MODE_LO];
    st_nxt.pin_smp = pin_in;
    external_interrupt_zero_now  = pin_in[GPCR_PIN_EXTERNAL_INTERRUPT_ZERO];
    external_interrupt_zero_prev = st_r.pin_smp[GPCR_PIN_EXTERNAL_INTERRUPT_ZERO];
    if (st_r.ctrl[GPCR_BIT_IRQ_POL]) begin
      edge_seen = external_interrupt_zero_now && !external_interrupt_zero_prev;
    end else begin
      edge_seen = !external_interrupt_zero_now && external_interrupt_zero_prev;
    end
    if (idx == GPCR_IDX_FUNC_CTRL) begin
      rd = st_r.ctrl;
    end else if (idx == GPCR_IDX_OUT_LO) begin
      rd = st_r.out_lo;
    end else if (idx == GPCR_IDX_IN_LO) begin
      rd = st_r.pin_smp[15:0];
    end else if (idx == GPCR_IDX_DIR_LO) begin
      rd = st_r.dir_lo;
    end else if (idx == GPCR_IDX_OUT_HI) begin
      rd = st_r.out_hi;
    end else if (idx == GPCR_IDX_IN_HI) begin
      rd = st_r.pin_smp[31:16] & GPCR_HI_MASK;
    end else if (idx == GPCR_IDX_DIR_HI) begin
      rd = st_r.dir_hi;
    end else if (idx == GPCR_IDX_IRQ_STAT) begin
      rd = {14'h0000, st_r.stat};
    end else if (idx == GPCR_IDX_IRQ_MASK) begin
      rd = {14'h0000, st_r.mask};
    end else if (idx == GPCR_IDX_CHIP_IEN) begin
      rd = {15'h0000, st_r.chip_ien};
    end else begin
      hit = 1'b0;
    end
    st_nxt.pready  = acc;
    st_nxt.pslverr = acc && !hit;
    st_nxt.prdata  = (acc && !pwrite_in && hit) ? {16'h0000, rd} : 32'h0000_0000;
    if (wr && idx == GPCR_IDX_FUNC_CTRL) begin
      st_nxt.ctrl = wd & GPCR_CTRL_WMASK;
      // other fields still take the write
      if (st_r.ctrl[GPCR_BIT_WPROT]) begin
        st_nxt.ctrl[GPCR_MODE_HI:GPCR_MODE_LO] = mode;
        // write protect itself stays set until reset
        st_nxt.ctrl[GPCR_BIT_WPROT] = 1'b1;
        if (wd[GPCR_MODE_HI:GPCR_MODE_LO] != mode) begin
          st_nxt.stat[GPCR_ST_WPV] = 1'b1;
        end
      end
    end
    if (wr && idx == GPCR_IDX_OUT_LO) begin
      st_nxt.out_lo = wd;
    end
    if (wr && idx == GPCR_IDX_DIR_LO) begin
      st_nxt.dir_lo = wd;
    end
    if (wr && idx == GPCR_IDX_OUT_HI) begin
      st_nxt.out_hi = wd & GPCR_HI_MASK;
    end
    if (wr && idx == GPCR_IDX_DIR_HI) begin
      st_nxt.dir_hi = wd & GPCR_HI_MASK;
    end
    if (wr && idx == GPCR_IDX_IRQ_MASK) begin
      st_nxt.mask = wd[GPCR_ST_W-1:0];
    end
    if (wr && idx == GPCR_IDX_CHIP_IEN) begin
      st_nxt.chip_ien = wd[0];
    end
    // write one to clear; a new event in the same cycle wins
    if (wr && idx == GPCR_IDX_IRQ_STAT) begin
      st_nxt.stat = st_nxt.stat & ~wd[GPCR_ST_W-1:0];
    end
    // pin 24 edge sets sticky status
    if (edge_seen && st_r.ctrl[GPCR_BIT_IRQ_EN] && st_r.chip_ien) begin
      st_nxt.stat[GPCR_ST_EXTERNAL_INTERRUPT_ZERO] = 1'b1;
    end
    if (wr && idx == GPCR_IDX_FUNC_CTRL && st_r.ctrl[GPCR_BIT_WPROT] &&
        wd[GPCR_MODE_HI:GPCR_MODE_LO] != mode) begin
      st_nxt.stat[GPCR_ST_WPV] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

    // low word on 15..0, high word on 31..29 and 24..19
    po = {st_r.out_hi, st_r.out_lo};
    oe = {st_r.dir_hi, st_r.dir_lo};
    // mode selects the owner of 15..0 and 24..19
    if (mode == GPCR_MODE_HOST) begin
      po[15:0]  = periph_in.host_do[15:0];
      oe[15:0]  = periph_in.host_oe[15:0];
      po[24:19] = periph_in.host_do[24:19];
      oe[24:19] = periph_in.host_oe[24:19];
    end
    if (st_r.ctrl[GPCR_BIT_SPI_EN]) begin
      po[11:8] = periph_in.spi_do;
      oe[11:8] = {4{periph_in.spi_oe}};
      // slave select moves to pin 15
      if (st_r.ctrl[GPCR_BIT_ALT_SS]) begin
        po[GPCR_PIN_SS_ALT]  = periph_in.spi_do[1];
        oe[GPCR_PIN_SS_ALT]  = periph_in.spi_oe;
        po[GPCR_PIN_SS_NORM] = st_r.out_lo[GPCR_PIN_SS_NORM];
        oe[GPCR_PIN_SS_NORM] = st_r.dir_lo[GPCR_PIN_SS_NORM];
      end
    end
    if (st_r.ctrl[GPCR_BIT_HSS_EN]) begin
      po[15:12] = periph_in.hss_do;
      oe[15:12] = {4{periph_in.hss_oe}};
      if (st_r.ctrl[GPCR_BIT_SPI_EN] && st_r.ctrl[GPCR_BIT_ALT_SS]) begin
        po[GPCR_PIN_SS_ALT] = periph_in.spi_do[1];
        oe[GPCR_PIN_SS_ALT] = periph_in.spi_oe;
      end
    end
    // transmitter enable status on pin 30
    if (st_r.ctrl[GPCR_BIT_TXEN_RT]) begin
      po[GPCR_PIN_TXEN] = periph_in.txen;
      oe[GPCR_PIN_TXEN] = 1'b1;
    end
    // unimplemented pins never drive
    oe[18:16] = 3'b000;
    oe[28:25] = 4'b0000;
    st_nxt.pin_o    = po;
    st_nxt.pin_oe_n = ~oe;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // reset clears control and data words
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r          <= '0;
      st_r.pin_oe_n <= 32'hffff_ffff;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready_out   = st_r.pready;
  assign prdata_out   = st_r.prdata;
  assign pslverr_out  = st_r.pslverr;
  assign pin_out      = st_r.pin_o;
  assign pin_oe_n_out = st_r.pin_oe_n;
  assign irq_out      = st_r.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mode_lock: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $past(st_r.ctrl[GPCR_BIT_WPROT]) |-> $stable(st_r.ctrl[GPCR_MODE_HI:GPCR_MODE_LO]))
    else $error("mode field changed while locked");
  a_txen_route: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    st_r.ctrl[GPCR_BIT_TXEN_RT] |=> !pin_oe_n_out[GPCR_PIN_TXEN]
      && pin_out[GPCR_PIN_TXEN] == $past(periph_in.txen))
    else $error("transmit enable not routed");
  a_alt_ss: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st_r.ctrl[GPCR_BIT_SPI_EN] && st_r.ctrl[GPCR_BIT_ALT_SS])
      |=> pin_out[GPCR_PIN_SS_ALT] == $past(periph_in.spi_do[1]))
    else $error("slave select not on alternate pin");
  a_spi_route: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st_r.ctrl[GPCR_BIT_SPI_EN] && !st_r.ctrl[GPCR_BIT_ALT_SS] && !st_r.ctrl[GPCR_BIT_TXEN_RT])
      |=> pin_out[11:8] == $past(periph_in.spi_do))
    else $error("serial peripheral not routed");
  a_hss_route: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st_r.ctrl[GPCR_BIT_HSS_EN] && !st_r.ctrl[GPCR_BIT_SPI_EN])
      |=> pin_out[15:12] == $past(periph_in.hss_do))
    else $error("high speed link not routed");
  a_irq_gate: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(st_r.stat[GPCR_ST_EXTERNAL_INTERRUPT_ZERO]) |-> $past(st_r.ctrl[GPCR_BIT_IRQ_EN] && st_r.chip_ien))
    else $error("interrupt set while disabled");
  a_irq_edge: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st_r.ctrl[GPCR_BIT_IRQ_EN] && st_r.chip_ien && st_r.ctrl[GPCR_BIT_IRQ_POL]
      && pin_in[GPCR_PIN_EXTERNAL_INTERRUPT_ZERO] && !st_r.pin_smp[GPCR_PIN_EXTERNAL_INTERRUPT_ZERO]) |=> st_r.stat[GPCR_ST_EXTERNAL_INTERRUPT_ZERO])
    else $error("rising edge missed");
  a_out_plain: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (st_r.ctrl == 16'h0000) |=> pin_out[7:0] == $past(st_r.out_lo[7:0])
      && pin_oe_n_out[7:0] == ~$past(st_r.dir_lo[7:0]))
    else $error("plain output mismatch");
  a_irq_out: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    irq_out == |(st_r.stat & st_r.mask))
    else $error("interrupt output mismatch");

endmodule

// >>> verif/gpcr_pin_model.sv
// partner: outside circuitry that resolves each pin and feeds its level back
`timescale 1ns/1ps
module gpcr_pin_model (
  input  wire logic [31:0] pin_o_in,
  input  wire logic [31:0] oe_n_in,
  input  wire logic [31:0] ext_in,
  output logic [31:0]      lvl_out
);
  // ---------------------------------------------------------------
  // pin resolution
  // ---------------------------------------------------------------
  // pin level seen
  // a released pin shows what the outside drives, never a held value
  assign lvl_out = (pin_o_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule

// >>> verif/test_gpio_control_and_pin_routing.sv
// testbench: register, pin routing and interrupt sequences for the pin block
`timescale 1ns/1ps
module test_gpio_control_and_pin_routing
  import gpcr_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         psel = 1'b0;
  logic         pen = 1'b0;
  logic         pwr = 1'b0;
  logic [31:0]  pa = '0;
  logic [31:0]  pw = '0;
  logic [3:0]   st = 4'hf;
  logic [31:0]  ext = 32'h0000_3c3c;
  gpcr_periph_s per = '0;
  logic [31:0]  lvl;
  logic [31:0]  prd;
  logic [31:0]  po;
  logic [31:0]  poe;
  logic         rdy;
  logic         err;
  logic         irq;
  int           n_fail = 0;
  int           compares = 0;

  always #5 clk = ~clk;

  gpcr_top dut_u (
    .core_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pw), .pstrb_in(st),
    .pin_in(lvl), .periph_in(per), .pready_out(rdy), .prdata_out(prd),
    .pslverr_out(err), .pin_out(po), .pin_oe_n_out(poe), .irq_out(irq)
  );

  gpcr_pin_model pins_u (.pin_o_in(po), .oe_n_in(poe), .ext_in(ext), .lvl_out(lvl));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; answer is taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1;
    pwr <= w;
    pa <= {14'h0000, idx, 2'b00};
    pw <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    // pready is read as it stands at the edge, before the design updates it
    do begin
      @(posedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      give_verdict();
    end
    q = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    // idle edge so the next request never reassigns psel in this step
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, idx, d, q, e);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [15:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, idx, 16'h0000, q, e);
    chk(q, {16'h0000, exp});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        e;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(GPCR_IDX_FUNC_CTRL, 16'h0000);
    rdc(GPCR_IDX_OUT_LO, 16'h0000);
    rdc(GPCR_IDX_OUT_HI, 16'h0000);
    chk(poe, 32'hffff_ffff);
    apb(1'b0, 16'hc000, 16'h0000, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    $display("test reset and map done");
    wr(GPCR_IDX_OUT_LO, 16'ha5c3);
    wr(GPCR_IDX_DIR_LO, 16'hffff);
    chk(po & 32'h0000_ffff, 32'h0000_a5c3);
    chk(poe & 32'h0000_ffff, 32'h0000_0000);
    wr(GPCR_IDX_DIR_LO, 16'h0000);
    rdc(GPCR_IDX_OUT_LO, 16'ha5c3);
    rdc(GPCR_IDX_IN_LO, 16'h3c3c);
    chk(poe & 32'h0000_ffff, 32'h0000_ffff);
    // a write without both low strobes must leave the register alone
    st <= 4'h1;
    wr(GPCR_IDX_OUT_LO, 16'h0000);
    st <= 4'hf;
    rdc(GPCR_IDX_OUT_LO, 16'ha5c3);
    // reserved bits written as zero; pin 24 kept an input for the interrupt
    wr(GPCR_IDX_OUT_HI, 16'he1f8);
    wr(GPCR_IDX_DIR_HI, 16'he0f8);
    rdc(GPCR_IDX_OUT_HI, 16'he1f8);
    chk(po & 32'he0f8_0000, 32'he0f8_0000);
    chk(poe & 32'he1f8_0000, 32'h0100_0000);
    $display("test pin data done");
    per <= '{1'b1, 4'ha, 1'b1, 4'h6, 1'b0, 32'hffff_ffff, 32'h0000_5a5a};
    wr(GPCR_IDX_OUT_LO, 16'h0000);
    wr(GPCR_IDX_DIR_LO, 16'hffff);
    wr(GPCR_IDX_FUNC_CTRL, 16'h0080);
    chk(po & 32'h0000_f000, 32'h0000_a000);
    wr(GPCR_IDX_FUNC_CTRL, 16'h0020);
    chk(po & 32'h0000_ff00, 32'h0000_0600);
    wr(GPCR_IDX_FUNC_CTRL, 16'h0820);
    chk(po & 32'h0000_8000, 32'h0000_8000);
    wr(GPCR_IDX_FUNC_CTRL, 16'h4000);
    chk(po & 32'h4000_0000, 32'h0000_0000);
    wr(GPCR_IDX_FUNC_CTRL, 16'h0000);
    chk(po & 32'h4000_0000, 32'h4000_0000);
    // only the plain and host port codes are selected in normal use
    wr(GPCR_IDX_FUNC_CTRL, 16'h0500);
    chk(po & 32'h0000_ffff, 32'h0000_5a5a);
    wr(GPCR_IDX_FUNC_CTRL, 16'h0000);
    chk(po & 32'h0000_ffff, 32'h0000_0000);
    $display("test routing done");
    wr(GPCR_IDX_CHIP_IEN, 16'h0001);
    wr(GPCR_IDX_IRQ_MASK, 16'h0001);
    wr(GPCR_IDX_FUNC_CTRL, 16'h0003);
    ext[24] <= 1'b1;
    rdc(GPCR_IDX_IRQ_STAT, 16'h0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(GPCR_IDX_IRQ_STAT, 16'h0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    ext[24] <= 1'b0;
    rdc(GPCR_IDX_IRQ_STAT, 16'h0000);
    wr(GPCR_IDX_FUNC_CTRL, 16'h0001);
    ext[24] <= 1'b1;
    rdc(GPCR_IDX_IRQ_STAT, 16'h0000);
    wr(GPCR_IDX_IRQ_MASK, 16'h0000);
    ext[24] <= 1'b0;
    rdc(GPCR_IDX_IRQ_STAT, 16'h0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(GPCR_IDX_IRQ_MASK, 16'h0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(GPCR_IDX_IRQ_STAT, 16'h0001);
    wr(GPCR_IDX_CHIP_IEN, 16'h0000);
    ext[24] <= 1'b1;
    rdc(GPCR_IDX_FUNC_CTRL, 16'h0001);
    ext[24] <= 1'b0;
    rdc(GPCR_IDX_IRQ_STAT, 16'h0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(GPCR_IDX_IRQ_STAT, 16'h0003);
    $display("test interrupt done");
    wr(GPCR_IDX_FUNC_CTRL, 16'h8500);
    wr(GPCR_IDX_FUNC_CTRL, 16'h4000);
    rdc(GPCR_IDX_FUNC_CTRL, 16'hc500);
    rdc(GPCR_IDX_IRQ_STAT, 16'h0002);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(GPCR_IDX_FUNC_CTRL, 16'h0000);
    rdc(GPCR_IDX_OUT_LO, 16'h0000);
    wr(GPCR_IDX_FUNC_CTRL, 16'h0500);
    rdc(GPCR_IDX_FUNC_CTRL, 16'h0500);
    $display("test lock and reset done");
    give_verdict();
  end
endmodule
